// >>> pfo_pkg.sv
/*
  shared constants of the fault override block: register indices, field
  positions, reset values and the fault latch state type.
  assumes a single 25 MHz clock and a simple strobe register port.
*/
`default_nettype none
// Notes on behaviour
// - fault A level bit: pin active or inactive
// - fault A mode set: cycle by cycle
// - fault A mode clear: fault latches levels
// - four pair enables gate fault A
// - fault B upper byte holds pin levels
// - bits six to four read zero
// - implemented bits read/write, reset zero
// - fault B mode set: cycle by cycle
package pfo_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] PFO_ADDR_FLTA = 4'h0;
  localparam logic [3:0] PFO_ADDR_FLTB = 4'h1;
  localparam logic [3:0] PFO_ADDR_STAT = 4'h2;
  localparam logic [3:0] PFO_ADDR_MASK = 4'h3;
  localparam logic [3:0] PFO_ADDR_CLR = 4'h4;
  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int PFO_MODE_BIT = 7;
  localparam logic [15:0] PFO_CTRL_IMPL = 16'hff8f;
  localparam logic [15:0] PFO_CTRL_RESET = 16'h0000;
  localparam logic [1:0] PFO_IRQ_RESET = 2'h0;
  // ****************************************************************
  // per fault latch state
  // ****************************************************************
  typedef enum logic [1:0] {PFO_IDLE, PFO_HOLD, PFO_CYCLE} pfo_state_e;
endpackage : pfo_pkg
`default_nettype wire

// >>> pfo_fault_ch.sv
/*
  one fault channel: decides whether its fault input owns the pins.
  assumes the fault input and period strobe are synchronous to CLK.
*/
`default_nettype none
module pfo_fault_ch
  import pfo_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic fault_in,
  input wire logic cycle_mode,
  input wire logic period_start,
  input wire logic latch_clear,
  output logic active,
  output logic event_p
);
  pfo_state_e state;
  pfo_state_e next_state;
  logic fault_d;
  logic next_fault_d;

  // next state: latched mode holds until software clears, cycle mode until period edge
  always_comb begin
    next_state = state;
    next_fault_d = fault_in;
    case (state)
      PFO_IDLE: begin
        if (fault_in) begin
          next_state = cycle_mode ? PFO_CYCLE : PFO_HOLD;
        end
      end
      PFO_HOLD: begin
        if (latch_clear && !fault_in) begin
          next_state = PFO_IDLE;
        end
      end
      PFO_CYCLE: begin
        if (!fault_in && period_start) begin
          next_state = PFO_IDLE;
        end
      end
      default: next_state = PFO_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= PFO_IDLE;
      fault_d <= 1'b0;
    end else begin
      state <= next_state;
      fault_d <= next_fault_d;
    end
  end

  assign active = (state != PFO_IDLE);
  assign event_p = fault_in && !fault_d;

  cyc_release_a: assert property (@(posedge CLK) disable iff (RST)
    (state == PFO_CYCLE && !fault_in && period_start) |=> state == PFO_IDLE)
    else $error("cycle mode did not release at period start");
  cyc_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (state == PFO_CYCLE && fault_in) |=> state == PFO_CYCLE)
    else $error("cycle mode released while fault asserted");
  latch_keep_a: assert property (@(posedge CLK) disable iff (RST)
    (state == PFO_HOLD && !latch_clear) |=> state == PFO_HOLD)
    else $error("latched fault released without clear");
  cover property (@(posedge CLK) disable iff (RST) state == PFO_HOLD ##1 state == PFO_IDLE);
  cover property (@(posedge CLK) disable iff (RST) state == PFO_CYCLE ##1 state == PFO_IDLE);
endmodule // pfo_fault_ch
`default_nettype wire

// >>> pfo_override.sv
/*
  fault override stage for four high/low output pairs with fault A and B.
  assumes the pwm generator supplies raw pin levels and a period strobe;
  active level of a pin is 1. registers reached over a strobe port.
*/
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
module pfo_override
  import pfo_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic FAULT_A,
  input wire logic FAULT_B,
  input wire logic PERIOD_START,
  input wire logic [7:0] PWM_IN,
  output logic [7:0] PWM_OUT,
  output logic [1:0] FAULT_ACTIVE,
  output logic IRQ
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] fault_a_control;
  logic [15:0] fault_b_control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [15:0] next_a;
  logic [15:0] next_b;
  logic [1:0] next_status;
  logic [1:0] next_mask;
  logic [15:0] next_rdata;
  logic [7:0] next_pwm;
  logic act_a;
  logic act_b;
  logic ev_a;
  logic ev_b;
  logic clr_a;
  logic clr_b;

  // expand four pair enables to eight pin enables (pin order h,l per pair)
  function automatic logic [7:0] pin_en(input logic [3:0] pairs);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[2*i] = pairs[i];
      r[2*i+1] = pairs[i];
    end
    return r;
  endfunction

  // software latch release: write to the clear register, bit 0 a, bit 1 b
  assign clr_a = WR && ADDR == PFO_ADDR_CLR && WDATA[0];
  assign clr_b = WR && ADDR == PFO_ADDR_CLR && WDATA[1];

  // fault channels
  pfo_fault_ch u_a (
    .CLK(CLK), .RST(RST), .fault_in(FAULT_A),
    .cycle_mode(fault_a_control[PFO_MODE_BIT]),
    .period_start(PERIOD_START), .latch_clear(clr_a),
    .active(act_a), .event_p(ev_a)
  );
  pfo_fault_ch u_b (
    .CLK(CLK), .RST(RST), .fault_in(FAULT_B),
    .cycle_mode(fault_b_control[PFO_MODE_BIT]),
    .period_start(PERIOD_START), .latch_clear(clr_b),
    .active(act_b), .event_p(ev_b)
  );

  // register writes, unimplemented bits masked off
  always_comb begin
    next_a = fault_a_control;
    next_b = fault_b_control;
    next_mask = irq_mask;
    next_status = irq_status;
    if (WR && ADDR == PFO_ADDR_FLTA) begin
      next_a = WDATA & PFO_CTRL_IMPL;
    end
    if (WR && ADDR == PFO_ADDR_FLTB) begin
      next_b = WDATA & PFO_CTRL_IMPL;
    end
    if (WR && ADDR == PFO_ADDR_MASK) begin
      next_mask = WDATA[1:0];
    end
    if (WR && ADDR == PFO_ADDR_STAT) begin
      next_status = irq_status & ~WDATA[1:0];
    end
    next_status = next_status | {ev_b, ev_a}; // set wins over clear
  end

  // read mux, unmapped reads return zero
  always_comb begin
    next_rdata = 16'h0000;
    if (RD) begin
      case (ADDR)
        PFO_ADDR_FLTA: next_rdata = fault_a_control;
        PFO_ADDR_FLTB: next_rdata = fault_b_control;
        PFO_ADDR_STAT: next_rdata = {14'h0000, irq_status};
        PFO_ADDR_MASK: next_rdata = {14'h0000, irq_mask};
        PFO_ADDR_CLR: next_rdata = {12'h000, act_b, act_a, FAULT_B, FAULT_A};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // output override: fault A takes priority over fault B on a shared pair
  always_comb begin
    logic [7:0] en_a;
    logic [7:0] en_b;
    en_a = pin_en(fault_a_control[3:0]) & {8{act_a}};
    en_b = pin_en(fault_b_control[3:0]) & {8{act_b}};
    next_pwm = PWM_IN;
    next_pwm = (next_pwm & ~en_b) | (fault_b_control[15:8] & en_b);
    next_pwm = (next_pwm & ~en_a) | (fault_a_control[15:8] & en_a);
  end

  // all state registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_a_control <= PFO_CTRL_RESET;
      fault_b_control <= PFO_CTRL_RESET;
      irq_status <= PFO_IRQ_RESET;
      irq_mask <= PFO_IRQ_RESET;
      RDATA <= 16'h0000;
      PWM_OUT <= 8'h00;
      FAULT_ACTIVE <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      fault_a_control <= next_a;
      fault_b_control <= next_b;
      irq_status <= next_status;
      irq_mask <= next_mask;
      RDATA <= next_rdata;
      PWM_OUT <= next_pwm;
      FAULT_ACTIVE <= {act_b, act_a};
      IRQ <= |(next_status & next_mask);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  reserved_zero_a: assert property (@(posedge CLK) disable iff (RST)
    (fault_a_control[6:4] == 3'h0) && (fault_b_control[6:4] == 3'h0))
    else $error("unimplemented control bits set");
  write_store_a: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == PFO_ADDR_FLTA) |=> fault_a_control == ($past(WDATA) & PFO_CTRL_IMPL))
    else $error("fault A control write lost");
  force_level_a: assert property (@(posedge CLK) disable iff (RST)
    (act_a && fault_a_control[0]) |=> PWM_OUT[1:0] == $past(fault_a_control[9:8]))
    else $error("pair one not forced to fault A level");
  inactive_drive_a: assert property (@(posedge CLK) disable iff (RST)
    (act_a && fault_a_control[1] && !fault_a_control[10]) |=> !PWM_OUT[2])
    else $error("cleared level bit did not drive inactive");
  pair_free_a: assert property (@(posedge CLK) disable iff (RST)
    (!fault_a_control[3] && !act_b) |=> PWM_OUT[7:6] == $past(PWM_IN[7:6]))
    else $error("disabled pair was overridden");
  b_level_a: assert property (@(posedge CLK) disable iff (RST)
    (act_b && !act_a && fault_b_control[2]) |=> PWM_OUT[5:4] == $past(fault_b_control[13:12]))
    else $error("pair three not forced to fault B level");
  latch_mode_a: assert property (@(posedge CLK) disable iff (RST)
    (FAULT_A && !act_a && !fault_a_control[PFO_MODE_BIT]) |=> ##1 FAULT_ACTIVE[0])
    else $error("fault A did not latch");
  // the interrupt line follows the registered status and mask
  irq_level_a: assert property (@(posedge CLK) disable iff (RST)
    IRQ == |(irq_status & irq_mask))
    else $error("interrupt line disagrees with status and mask");
  // a fault edge always lands in status, even beside a clear write
  status_set_a: assert property (@(posedge CLK) disable iff (RST)
    ev_a |=> irq_status[0])
    else $error("fault A event not recorded");
  status_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == PFO_ADDR_STAT && WDATA[0] && !ev_a) |=> !irq_status[0])
    else $error("status bit not cleared by write of one");
  mask_store_a: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == PFO_ADDR_MASK) |=> irq_mask == $past(WDATA[1:0]))
    else $error("mask write lost");
  b_store_a: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == PFO_ADDR_FLTB) |=> fault_b_control == ($past(WDATA) & PFO_CTRL_IMPL))
    else $error("fault B control write lost");
  // read data stand only in the cycle after the strobe
  read_idle_a: assert property (@(posedge CLK) disable iff (RST)
    !RD |=> RDATA == 16'h0000)
    else $error("read data shown without a read");
  read_ctrl_a: assert property (@(posedge CLK) disable iff (RST)
    (RD && ADDR == PFO_ADDR_FLTA) |=> RDATA == $past(fault_a_control))
    else $error("fault A control read wrong");
  unmapped_read_a: assert property (@(posedge CLK) disable iff (RST)
    (RD && ADDR > PFO_ADDR_CLR) |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  // fault A wins a pair that both faults own
  a_priority_a: assert property (@(posedge CLK) disable iff (RST)
    (act_a && act_b && fault_a_control[1] && fault_b_control[1]) |=>
      PWM_OUT[3:2] == $past(fault_a_control[11:10]))
    else $error("fault B overrode fault A on a shared pair");
  // with no fault owning the pins the raw levels pass through
  free_pins_a: assert property (@(posedge CLK) disable iff (RST)
    (!act_a && !act_b) |=> PWM_OUT == $past(PWM_IN))
    else $error("pins overridden with no fault active");
  cover property (@(posedge CLK) disable iff (RST) act_a && act_b);
  cover property (@(posedge CLK) disable iff (RST) IRQ);
endmodule // pfo_override
`default_nettype wire

// >>> pfo_fault_src.sv
/*
  partner model: fault sense inputs of the power output stage.
  assumes fault requests come from the bench on rising CLK edges.
*/
`default_nettype none
module pfo_fault_src (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] req,
  output logic fault_a,
  output logic fault_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // sense comparators are registered, so a fault pin lags its request by one cycle
  always_ff @(posedge CLK) begin
    fault_a <= RST ? 1'b0 : req[0];
    fault_b <= RST ? 1'b0 : req[1];
  end
endmodule // pfo_fault_src
`default_nettype wire

// >>> pfo_override_bench.sv
/*
  self-checking bench of the fault override block with a fault sense model.
  assumes the register port answers a read one cycle later.
*/
`default_nettype none
module pfo_override_bench;
  import pfo_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic PERIOD_START = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [7:0] PWM_IN = 8'h5a;
  logic [1:0] req = 2'h0;
  logic [15:0] RDATA;
  logic [7:0] PWM_OUT;
  logic [1:0] FAULT_ACTIVE;
  logic FAULT_A;
  logic FAULT_B;
  logic IRQ;
  int n_errors = 0;
  int n_checks = 0;
  pfo_override pfo_override_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .FAULT_A(FAULT_A), .FAULT_B(FAULT_B), .PERIOD_START(PERIOD_START),
    .PWM_IN(PWM_IN), .PWM_OUT(PWM_OUT), .FAULT_ACTIVE(FAULT_ACTIVE), .IRQ(IRQ));
  pfo_fault_src pfo_fault_src_i (.CLK(CLK), .RST(RST), .req(req), .fault_a(FAULT_A), .fault_b(FAULT_B));
  // 25 MHz clock
  initial begin
    forever #20 CLK = ~CLK;
  end
  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic cmp(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 cmp("rdata", RDATA, exp);
  endtask
  // pins settle one cycle after the fault pin is sampled
  task automatic pins(input logic [7:0] exp);
    repeat (3) @(posedge CLK);
    #1 cmp("pwm_out", {8'h00, PWM_OUT}, {8'h00, exp});
  endtask
  // raise a fault, drop it, then pass a period boundary
  task automatic run(input logic [3:0] a, input logic [15:0] ctl, input logic [1:0] f,
                     input logic [7:0] exp, input logic [7:0] after);
    wr(a, ctl);
    @(posedge CLK);
    req <= f;
    pins(exp);
    cmp("fault_active", {14'h0000, FAULT_ACTIVE}, {14'h0000, f});
    @(posedge CLK);
    req <= 2'h0;
    pins(exp);
    @(posedge CLK);
    PERIOD_START <= 1'b1;
    @(posedge CLK);
    PERIOD_START <= 1'b0;
    pins(after);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd_chk(PFO_ADDR_FLTA, 16'h0000);
    rd_chk(PFO_ADDR_FLTB, 16'h0000);
    wr(PFO_ADDR_FLTA, 16'hffff);
    rd_chk(PFO_ADDR_FLTA, 16'hff8f);
    wr(PFO_ADDR_FLTB, 16'hffff);
    rd_chk(PFO_ADDR_FLTB, 16'hff8f);
    rd_chk(4'hf, 16'h0000);
    wr(PFO_ADDR_FLTB, 16'h0000);
    wr(PFO_ADDR_MASK, 16'h0001);
    $display("test registers done");
    run(PFO_ADDR_FLTA, 16'ha501, 2'h1, 8'h59, 8'h59);
    cmp("irq", {15'h0000, IRQ}, 16'h0001);
    rd_chk(PFO_ADDR_STAT, 16'h0001);
    rd_chk(PFO_ADDR_CLR, 16'h0004);
    wr(PFO_ADDR_STAT, 16'h0001);
    wr(PFO_ADDR_CLR, 16'h0001);
    pins(8'h5a);
    cmp("fault_active", {14'h0000, FAULT_ACTIVE}, 16'h0000);
    cmp("irq", {15'h0000, IRQ}, 16'h0000);
    wr(PFO_ADDR_FLTA, 16'h0000);
    $display("test latched fault done");
    run(PFO_ADDR_FLTA, 16'h0c82, 2'h1, 8'h5e, 8'h5a);
    wr(PFO_ADDR_FLTA, 16'h0000);
    run(PFO_ADDR_FLTB, 16'hf388, 2'h2, 8'hda, 8'h5a);
    $display("test cycle faults done");
    report_and_stop;
  end
  // watchdog at 5000 cycles, far beyond the fewer than one hundred cycles the tests take
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
endmodule // pfo_override_bench
`default_nettype wire
